/* design/smbus_slave_read_sequencer.sv */
// Purpose: slave-side read transfer sequencing on a two-wire smbus link
// Assumes: classic wishbone slave, link lines sampled by clk_i
// Notes: open-drain outputs only ever pull low
//
// Notes on behaviour
// - the address byte is received and later data bytes are transmitted while software loads them.
// - transmitter mode is entered on start plus matching read address, only if not inhibited and the acknowledge bit is set.
// - entering on an address raises the interrupt flag and the acknowledge-request flag.
// - address and byte-sent interrupts come only after the acknowledge bit has ended.
// - after a nacked address the interrupt flag is not set until the next start.
// - after an accepted address software loads data and bytes go out while the master asks.
// - loading data after a master nack in transmitter mode flags an error.
// - a stop on the bus ends transmitter mode.
// - no data loaded after a transmit interrupt drops back to receiver mode.
// - a four-bit status vector shows transmit direction, start and stop flags; its master bit is tied low.
// - response combinations outside the bus specification are tolerated.
//
// Chosen here: the address map and register access over Wishbone.

`timescale 1ns/1ns
`default_nettype none

module smbus_slave_read_sequencer
    import smbus_read_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [3:0] status_vector_o,
    output logic irq_o
);

    // ************************************************************
    // link sampling
    // ************************************************************
    logic scl, scl_rise, scl_fall;
    logic sda, sda_rise, sda_fall;

    line_sync scl_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line_i(scl_i),
        .level_o(scl),
        .rise_o(scl_rise),
        .fall_o(scl_fall)
    );

    line_sync sda_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line_i(sda_i),
        .level_o(sda),
        .rise_o(sda_rise),
        .fall_o(sda_fall)
    );

    logic start_det, stop_det;
    assign start_det = sda_fall && scl;
    assign stop_det = sda_rise && scl;

    // ************************************************************
    // state and software-visible flags
    // ************************************************************
    seq_state_type state;
    logic [3:0] cnt;
    logic [7:0] shift_q;
    logic [7:0] data_reg;
    logic data_loaded;
    logic ack_ctl, si, ack_request_flag, sta_flag, sto_flag, master_ack;
    logic [ev_width-1:0] stat, mask;
    logic [7:0] cfg;
    logic hold, transmit_direction_flag, addr_match, release_hold;
    logic si_set, ev_addr_p, ev_err_p;
    logic wb_req, wr, wr_ctrl, wr_data;

    assign hold = (state == st_hold_addr) || (state == st_hold_tx);
    assign transmit_direction_flag = (state == st_tx) || (state == st_hold_tx);
    assign release_hold = hold && !si;
    assign addr_match = (shift_q[7:1] == cfg[6:0]) && shift_q[0]
        && !cfg[cfg_inhibit_bit];

    // ************************************************************
    // wishbone slave: ack one cycle after request, writes on ack edge
    // ************************************************************
    assign wb_req = cyc_i && stb_i;
    assign wr = wb_req && ack_o && we_i && sel_i[0];
    assign wr_ctrl = wr && (adr_i == ctrl_off);
    assign wr_data = wr && (adr_i == data_off);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= wb_req && !ack_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (wb_req && !ack_o)
        begin
            case (adr_i)
                ctrl_off: dat_o <= {24'h00_0000, 1'b0, transmit_direction_flag, sta_flag, sto_flag,
                    ack_request_flag, 1'b0, transmit_direction_flag ? master_ack : ack_ctl, si};
                data_off: dat_o <= {24'h00_0000, data_reg};
                stat_off: dat_o <= {28'h000_0000, stat};
                mask_off: dat_o <= {28'h000_0000, mask};
                cfg_off: dat_o <= {24'h00_0000, cfg};
                default: dat_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mask <= mask_reset;
            cfg <= cfg_reset;
            ack_ctl <= ctrl_ack_reset;
        end
        else
        begin
            if (wr && adr_i == mask_off)
                mask <= dat_i[ev_width-1:0];
            if (wr && adr_i == cfg_off)
                cfg <= dat_i[7:0];
            if (wr_ctrl)
                ack_ctl <= dat_i[ctrl_ack_bit];
        end
    end

    // ************************************************************
    // interrupt flag and request flags: hardware set wins over clear
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            si <= 1'b0;
        else if (si_set)
            si <= 1'b1;
        else if (wr_ctrl && !dat_i[ctrl_si_bit])
            si <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_request_flag <= 1'b0;
        else if (ev_addr_p)
            ack_request_flag <= 1'b1;
        else if (release_hold || state == st_idle)
            ack_request_flag <= 1'b0;
    end

    // start/stop seen; master-only controls in the same register are
    // accepted and ignored rather than faulted
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sta_flag <= 1'b0;
            sto_flag <= 1'b0;
        end
        else
        begin
            if (start_det)
                sta_flag <= 1'b1;
            else if (wr_ctrl && !dat_i[ctrl_sta_bit])
                sta_flag <= 1'b0;
            if (stop_det)
                sto_flag <= 1'b1;
            else if (wr_ctrl && !dat_i[ctrl_sto_bit])
                sto_flag <= 1'b0;
        end
    end

    assign status_vector_o = {1'b0, transmit_direction_flag, sta_flag, sto_flag};

    // ************************************************************
    // data register; a late load after nack is stored but never sent
    // ************************************************************
    assign ev_err_p = wr_data && state == st_hold_tx && !master_ack;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_reg <= 8'h00;
            data_loaded <= 1'b0;
        end
        else if (wr_data)
        begin
            data_reg <= dat_i[7:0];
            data_loaded <= 1'b1;
        end
        else if (release_hold || state == st_idle)
            data_loaded <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stat <= '0;
        else
            stat <= (stat & ~((wr && adr_i == stat_off) ? dat_i[ev_width-1:0] : '0))
                | {ev_err_p, stop_det && state != st_idle,
                   si_set && state == st_tx, ev_addr_p};
    end

    assign irq_o = |(stat & mask);

    // ************************************************************
    // sequencer
    // ************************************************************
    logic load_shift, do_shift;
    assign ev_addr_p = state == st_addr_ack && scl_fall && !stop_det && !start_det;
    assign si_set = ev_addr_p
        || (state == st_tx && scl_fall && cnt == byte_bits && !stop_det && !start_det);
    assign load_shift = release_hold && data_loaded
        && (state == st_hold_addr || master_ack);
    assign do_shift = (state == st_addr && scl_rise && cnt < byte_bits)
        || (state == st_tx && scl_fall && cnt < byte_bits);

    byte_shifter #(.width(8)) shifter
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load_shift),
        .data_i(data_reg),
        .shift_i(do_shift),
        .bit_i(sda),
        .q_o(shift_q)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt <= 4'h0;
        else if (start_det || load_shift)
            cnt <= 4'h0;
        else if (do_shift)
            cnt <= cnt + 4'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            master_ack <= 1'b0;
        else if (state == st_tx && scl_rise && cnt == byte_bits)
            master_ack <= !sda;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= st_idle;
        else if (stop_det)
            state <= st_idle;
        else if (start_det)
            state <= st_addr;
        else
        begin
            case (state)
                st_addr:
                    if (scl_fall && cnt == byte_bits)
                        state <= (addr_match && ack_ctl) ? st_addr_ack : st_wait;
                st_addr_ack:
                    if (scl_fall)
                        state <= st_hold_addr;
                st_hold_addr, st_hold_tx:
                    if (!si)
                        state <= load_shift ? st_tx : st_wait;
                st_tx:
                    if (scl_fall && cnt == byte_bits)
                        state <= st_hold_tx;
                default: state <= state;
            endcase
        end
    end

    // ************************************************************
    // open-drain drive, registered so both lines move together
    // ************************************************************
    logic next_sda_oe;
    assign next_sda_oe = (state == st_addr_ack)
        || (state == st_tx && cnt < byte_bits && !shift_q[7]);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end
        else
        begin
            sda_oe_o <= next_sda_oe && !stop_det && !start_det;
            scl_oe_o <= hold && si;
        end
    end

    assign sda_o = 1'b0;
    assign scl_o = 1'b0;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    inhibit_entry_a: assert property ((state == st_addr && scl_fall && cnt == byte_bits
        && cfg[cfg_inhibit_bit]) |=> state != st_addr_ack) else $error("entry while inhibited");
    ack_request_flag_set_a: assert property ($rose(si) && state == st_hold_addr |-> ack_request_flag)
        else $error("ack request not set");
    irq_after_ack_a: assert property ($rose(si) |-> $past(scl_fall)
        && ($past(state) == st_addr_ack || $past(state) == st_tx)) else $error("early irq");
    nack_quiet_a: assert property (state == st_wait |=> !$rose(si))
        else $error("irq after nack");
    tx_entry_a: assert property ((state == st_hold_addr && !si && data_loaded
        && !stop_det && !start_det) |=> state == st_tx ##1 sda_oe_o == !shift_q[7])
        else $error("tx not entered");
    load_error_a: assert property ((wr_data && state == st_hold_tx && !master_ack)
        |=> stat[ev_error]) else $error("error flag missing");
    stop_exit_a: assert property (stop_det |=> state == st_idle && !status_vector_o[2])
        else $error("stop not honoured");
    fallback_a: assert property ((state == st_hold_tx && !si && !data_loaded
        && !stop_det && !start_det) |=> state == st_wait) else $error("no fallback");
    stretch_a: assert property ((hold && si) |=> scl_oe_o)
        else $error("clock not held");
    drive_role_a: assert property ($rose(sda_oe_o) |-> $past(state) == st_addr_ack
        || $past(state) == st_tx) else $error("drive in receive phase");

    addr_taken_c: cover property (state == st_addr_ack ##[1:200] state == st_hold_addr);
    byte_sent_c: cover property (state == st_tx ##[1:400] state == st_hold_tx);
    fallback_c: cover property (state == st_hold_tx ##[1:200] state == st_wait);
    stop_seen_c: cover property (transmit_direction_flag ##[1:400] stop_det);

endmodule : smbus_slave_read_sequencer

`default_nettype wire

/* design/smbus_read_pkg.sv */
// Purpose: shared constants and types for the smbus slave read sequencer
// Assumes: 32-bit classic wishbone, registers in the low byte lane
// Notes: bit positions follow the control register layout seen by software

package smbus_read_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] data_off = 8'h04;
    localparam logic [7:0] stat_off = 8'h08;
    localparam logic [7:0] mask_off = 8'h0c;
    localparam logic [7:0] cfg_off = 8'h10;

    // ************************************************************
    // bus_control_reg fields
    // ************************************************************
    localparam int ctrl_master_bit = 7;
    localparam int ctrl_tx_bit = 6;
    localparam int ctrl_sta_bit = 5;
    localparam int ctrl_sto_bit = 4;
    localparam int ctrl_ack_request_flag_bit = 3;
    localparam int ctrl_ack_bit = 1;
    localparam int ctrl_si_bit = 0;
    localparam logic ctrl_ack_reset = 1'b1;

    // ************************************************************
    // event status / mask fields
    // ************************************************************
    localparam int ev_width = 4;
    localparam int ev_addr = 0;
    localparam int ev_byte = 1;
    localparam int ev_stop = 2;
    localparam int ev_error = 3;
    localparam logic [3:0] mask_reset = 4'h0;

    // ************************************************************
    // configuration register: own address and address-match inhibit
    // ************************************************************
    localparam int cfg_inhibit_bit = 7;
    localparam logic [7:0] cfg_reset = 8'h80;

    localparam logic [3:0] byte_bits = 4'h8;

    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_hold_addr,
        st_tx,
        st_hold_tx,
        st_wait
    } seq_state_type;

endpackage : smbus_read_pkg

/* design/line_sync.sv */
// Purpose: two-flop synchroniser with edge detection for one bus line
// Assumes: line idles high (pull-up)
// Notes: only the second flop and later stages feed logic

`timescale 1ns/1ns
`default_nettype none

module line_sync
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic line_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta;
    logic prev;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= 1'b1;
            level_o <= 1'b1;
            prev <= 1'b1;
        end
        else
        begin
            meta <= line_i;
            level_o <= meta;
            prev <= level_o;
        end
    end

    assign rise_o = level_o && !prev;
    assign fall_o = !level_o && prev;
endmodule : line_sync

`default_nettype wire

/* design/byte_shifter.sv */
// Purpose: msb-first shift register shared by address receive and data send
// Assumes: load wins over shift
// Notes: width is a parameter, default one byte

`timescale 1ns/1ns
`default_nettype none

module byte_shifter
#(
    parameter int width = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [width-1:0] data_i,
    input wire logic shift_i,
    input wire logic bit_i,
    output logic [width-1:0] q_o
);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q_o <= '0;
        else if (load_i)
            q_o <= data_i;
        else if (shift_i)
            q_o <= {q_o[width-2:0], bit_i};
    end
endmodule : byte_shifter

`default_nettype wire

/* tb/smbus_master_model.sv */
// Purpose: behavioural smbus master reading from the slave
// Assumes: open-drain lines with pull-ups, 160 ns bus clock period
// Notes: scl stands high between frames; a released line reads 1
`timescale 1ns/1ns
`default_nettype none
module smbus_master_model
(
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o,
    output logic [7:0] rx_byte_o,
    output logic rx_stb_o,
    output logic ack_seen_o
);
    localparam int half_ns = 80;
    localparam int qtr_ns = 40;
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        rx_byte_o = 8'h00;
        rx_stb_o = 1'b0;
        ack_seen_o = 1'b0;
    end
    // ************************************************************
    // bit and frame level
    // ************************************************************
    // waiting on the wire level honours clock stretching by the slave
    task automatic put_bit(input logic b);
        sda_o = b;
        #qtr_ns scl_o = 1'b1;
        wait (scl_i === 1'b1);
        #half_ns scl_o = 1'b0;
        #qtr_ns;
    endtask : put_bit
    task automatic get_bit(output logic b);
        sda_o = 1'b1;
        #qtr_ns scl_o = 1'b1;
        wait (scl_i === 1'b1);
        #qtr_ns b = sda_i;
        #qtr_ns scl_o = 1'b0;
        #qtr_ns;
    endtask : get_bit
    task automatic start_cond();
        sda_o = 1'b1;
        #qtr_ns scl_o = 1'b1;
        wait (scl_i === 1'b1);
        #half_ns sda_o = 1'b0;
        #half_ns scl_o = 1'b0;
        #qtr_ns;
    endtask : start_cond
    task automatic stop_cond();
        sda_o = 1'b0;
        #qtr_ns scl_o = 1'b1;
        wait (scl_i === 1'b1);
        #half_ns sda_o = 1'b1;
        #half_ns;
    endtask : stop_cond
    task automatic address(input logic [6:0] a, input logic rd);
        logic b;
        start_cond();
        for (int i = 6; i >= 0; i--)
            put_bit(a[i]);
        put_bit(rd);
        get_bit(b);
        ack_seen_o = ~b;
    endtask : address
    task automatic read_byte(input logic ack);
        logic [7:0] d;
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(~ack);
        rx_byte_o = d;
        rx_stb_o = 1'b1;
        #8 rx_stb_o = 1'b0;
    endtask : read_byte
endmodule : smbus_master_model
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench for the smbus slave read sequencer
// Assumes: software and the bus master run in one thread
// Notes: the master holds scl low between bytes, so software may take its time
`timescale 1ns/1ns
`default_nettype none
module tb;
    import smbus_read_pkg::*;
    typedef struct {logic [31:0] exp; logic [31:0] mask;} note_type;
    localparam int max_cycles = 40000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [3:0] status_vector_o;
    logic ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o;
    logic m_scl, m_sda, scl_w, sda_w, rx_stb, ack_seen;
    logic [7:0] rx_byte;
    logic [6:0] own;
    logic [31:0] d;
    note_type n;
    note_type reg_q[$];
    logic [7:0] byte_q[$];
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #4 clk_i = ~clk_i;
    // open-drain wires: whoever pulls low wins over the pull-up
    assign scl_w = m_scl & (scl_oe_o ? scl_o : 1'b1);
    assign sda_w = m_sda & (sda_oe_o ? sda_o : 1'b1);
    smbus_slave_read_sequencer u_smbus_slave_read_sequencer (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .status_vector_o(status_vector_o),
        .irq_o(irq_o));
    smbus_master_model u_smbus_master_model (
        .scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda),
        .rx_byte_o(rx_byte), .rx_stb_o(rx_stb), .ack_seen_o(ack_seen));
    // ************************************************************
    // checking and bus tasks
    // ************************************************************
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_pin(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask : cmp_pin
    task automatic results();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= v;
        sel_i <= 4'hf;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        reg_q.push_back('{e, m});
        wb(1'b0, a, 32'h0);
    endtask : rd
    // read data is taken at the edge that sees ack, as the bus master does
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == max_cycles)
        begin
            n_fail++;
            results();
        end
        if (ack_o === 1'b1 && we_i === 1'b0 && reg_q.size() > 0)
        begin
            n = reg_q.pop_front();
            cmp_word(dat_o & n.mask, n.exp & n.mask);
        end
    end
    always @(posedge rx_stb)
        cmp_word({24'h0, rx_byte}, {24'h0, byte_q.pop_front()});
    initial
    begin
        void'($urandom(58806));
        own = 7'($urandom_range(126, 1));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ctrl_off, 32'h02, 32'hffff_fffb);
        rd(mask_off, {28'h0, mask_reset}, '1);
        rd(cfg_off, {24'h0, cfg_reset}, '1);
        rd(stat_off, 32'h0, '1);
        rd(8'h14, 32'h0, '1);
        cmp_word({28'h0, status_vector_o}, 32'h0);
        $display("reset values done");
        u_smbus_master_model.address(7'h00, 1'b1);
        cmp_pin(ack_seen, 1'b0);
        u_smbus_master_model.stop_cond();
        wb(1'b1, cfg_off, {25'h0, own});
        u_smbus_master_model.address(own ^ 7'h01, 1'b1);
        cmp_pin(ack_seen, 1'b0);
        u_smbus_master_model.stop_cond();
        u_smbus_master_model.address(own, 1'b0);
        cmp_pin(ack_seen, 1'b0);
        u_smbus_master_model.stop_cond();
        wb(1'b1, stat_off, 32'hf);
        $display("refused addresses done");
        u_smbus_master_model.address(own, 1'b1);
        cmp_pin(ack_seen, 1'b1);
        rd(ctrl_off, 32'h09, 32'h09);
        rd(stat_off, 32'h01, 32'h01);
        rd(cfg_off, {25'h0, own}, 32'hff);
        @(negedge clk_i);
        cmp_word({30'h0, status_vector_o[1:0]}, 32'h3);
        cmp_pin(irq_o, 1'b0);
        cmp_pin(scl_oe_o, 1'b1);
        cmp_pin(scl_o, 1'b0);
        cmp_pin(sda_o, 1'b0);
        wb(1'b1, mask_off, 32'hf);
        @(negedge clk_i);
        cmp_pin(irq_o, 1'b1);
        wb(1'b1, stat_off, 32'h1);
        @(negedge clk_i);
        cmp_pin(irq_o, 1'b0);
        for (int k = 0; k < 3; k++)
        begin
            d = $urandom() & 32'hff;
            wb(1'b1, data_off, d);
            rd(data_off, d, 32'hff);
            wb(1'b1, ctrl_off, 32'h02);
            byte_q.push_back(d[7:0]);
            u_smbus_master_model.read_byte(k < 2);
            rd(stat_off, 32'h02, 32'h02);
            cmp_word({30'h0, status_vector_o[3:2]}, 32'h1);
            wb(1'b1, stat_off, 32'h2);
        end
        rd(ctrl_off, 32'h01, 32'h03);
        wb(1'b1, data_off, 32'h5a);
        rd(stat_off, 32'h08, 32'h08);
        wb(1'b1, ctrl_off, 32'h02);
        u_smbus_master_model.stop_cond();
        rd(stat_off, 32'h04, 32'h04);
        cmp_word({30'h0, status_vector_o[3:2]}, 32'h0);
        wb(1'b1, stat_off, 32'hf);
        $display("read transfer done");
        u_smbus_master_model.address(own, 1'b1);
        d = $urandom() & 32'hff;
        wb(1'b1, data_off, d);
        wb(1'b1, ctrl_off, 32'h02);
        byte_q.push_back(d[7:0]);
        u_smbus_master_model.read_byte(1'b1);
        wb(1'b1, stat_off, 32'hf);
        wb(1'b1, ctrl_off, 32'h02);
        byte_q.push_back(8'hff);
        u_smbus_master_model.read_byte(1'b1);
        rd(stat_off, 32'h0, 32'h02);
        u_smbus_master_model.stop_cond();
        wb(1'b1, stat_off, 32'hf);
        $display("receiver fallback done");
        wb(1'b1, ctrl_off, 32'h00);
        u_smbus_master_model.address(own, 1'b1);
        cmp_pin(ack_seen, 1'b0);
        rd(stat_off, 32'h0, 32'h01);
        wb(1'b1, ctrl_off, 32'h02);
        u_smbus_master_model.address(own, 1'b1);
        cmp_pin(ack_seen, 1'b1);
        rd(stat_off, 32'h01, 32'h01);
        wb(1'b1, ctrl_off, 32'h02);
        u_smbus_master_model.stop_cond();
        @(negedge clk_i);
        cmp_pin(irq_o, 1'b1);
        wb(1'b1, stat_off, 32'hf);
        @(negedge clk_i);
        cmp_pin(irq_o, 1'b0);
        $display("ignored address done");
        results();
    end
endmodule : tb
`default_nettype wire
